//--- design/vps_map.svh
// Register offsets, field positions and reset values of the video post-processor stream control
`ifndef VPS_MAP_SVH
`define VPS_MAP_SVH
`define VPS_OFF_STREAM_CTRL 12'h3D0
`define VPS_OFF_SRC_LUMA 12'h3D4
`define VPS_OFF_SRC_CHROMA 12'h3D8
`define VPS_OFF_ADDR_MODE 12'h3DC
`define VPS_RST_WORD 32'h00000000
`define VPS_F_FMT_HI 31
`define VPS_F_FMT_LO 28
`define VPS_B_ENABLE 27
`define VPS_B_TRIPLE 26
`define VPS_F_SRC_HI 25
`define VPS_F_SRC_LO 24
`define VPS_B_ADV_DEINT 23
`define VPS_B_VLPF 22
`define VPS_B_CHROMA_FIELD 20
`define VPS_B_INV_FIELD 19
`define VPS_B_FRAME2FIELD 18
`define VPS_B_FIELD2FRAME 17
`define VPS_B_SUBPIC_FLIP 15
`define VPS_B_FLIPQ_FULL 12
`define VPS_F_FSM_HI 10
`define VPS_F_FSM_LO 8
`define VPS_B_IRQ_EN 7
`define VPS_B_SINGLE 6
`define VPS_B_SW_BOTTOM 5
`define VPS_B_SW_FLIP 4
`define VPS_B_IDLE 3
`define VPS_F_BUFID_HI 2
`define VPS_F_BUFID_LO 1
`define VPS_B_EOF 0
`define VPS_STRM_RW_MASK 32'hFFDE00E0
`define VPS_ADDR_RW_MASK 32'h1FFFFFF3
`define VPS_MODE_RW_MASK 32'hF9F0E7FF
`define VPS_F_TILE_HI 31
`define VPS_F_TILE_LO 30
`define VPS_B_PACK32 29
`define VPS_B_CSC 28
`define VPS_B_DEBLOCK 27
`define VPS_F_THR_HI 24
`define VPS_F_THR_LO 20
`define VPS_B_ALPHA_FF 15
`define VPS_B_PIPE_SYNC 14
`define VPS_B_PIPE_INV 13
`define VPS_F_SIZE_HI 10
`define VPS_F_SIZE_LO 0
`define VPS_FIFO_LEVELS 64
`define VPS_FIFO_BASE_THR 32
`define VPS_FRAME_TIME_NS 1000
`define VPS_CLK_NS 5
`define VPS_FRAME_CYC ((`VPS_FRAME_TIME_NS + `VPS_CLK_NS - 1) / `VPS_CLK_NS)
`define VPS_BLEND_CYC 16
`endif

//--- design/vps_pkg.sv
// Types shared by the stream control block
`default_nettype none
package vps_pkg;
    typedef enum logic [2:0] {
        VPS_IDLE,
        VPS_LOAD,
        VPS_RUN,
        VPS_DRAIN,
        VPS_DONE
    } vps_state_e;
    typedef logic [31:0] vps_word_t;
endpackage : vps_pkg
`default_nettype wire

//--- design/vps_fifo_level.sv
// Output FIFO fill tracker raising the memory write request at threshold
`timescale 1ns/1ps
`default_nettype none
`include "vps_map.svh"
module vps_fifo_level
    import vps_pkg::*;
#(
    parameter int LEVELS = `VPS_FIFO_LEVELS
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic push,
    input wire logic pop,
    input wire logic [4:0] thr_extra,
    output logic wr_req,
    output logic full,
    output logic [6:0] level
);
    logic [6:0] level_r;
    logic [6:0] thr;
    // Fill counter; a push into a full FIFO is dropped
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            level_r <= 7'h00;
        end else if (push && !pop && level_r != 7'(LEVELS)) begin
            level_r <= level_r + 7'h01;
        end else if (pop && !push && level_r != 7'h00) begin
            level_r <= level_r - 7'h01;
        end
    end
    assign thr = 7'(`VPS_FIFO_BASE_THR) + {2'h0, thr_extra};
    assign wr_req = (level_r >= thr);
    assign full = (level_r == 7'(LEVELS));
    assign level = level_r;
    AST_WRREQ_THR: assert property (@(posedge MCLK) disable iff (SRST)
        (level_r == thr) |-> wr_req) else $error("write request missing at threshold");
    AST_FIFO_CAP: assert property (@(posedge MCLK) disable iff (SRST)
        level_r <= 7'(LEVELS)) else $error("fifo level above capacity");
endmodule : vps_fifo_level
`default_nettype wire

//--- design/vps_stream_ctrl.sv
// Stream control and status register bank of the video post-processor, APB slave
`timescale 1ns/1ps
`default_nettype none
`include "vps_map.svh"
// Notes on behaviour
// - Format field bits 31:28 picks the pixel layout; unlisted codes are reserved.
// - Engine processes only while enable bit 27 is set.
// - Bit 26 selects two (0) or three (1) destination buffers.
// - Source bits 25:24: 00 software, 10 capture 0, 11 capture 1.
// - Bit 23 advanced de-interlace, bit 22 vertical low-pass filter.
// - Bit 20 tells chroma plane is frame (0) or field (1) picture.
// - Bit 18 extracts a field from a frame; bit 19 inverts field sense.
// - Bit 17 de-interlaces a field source into progressive frames.
// - Software sets bit 15 for sub-picture blend; hardware clears it when done.
// - Read-only flip queue full at bit 12, flip state in bits 10:8.
// - Bit 7 enables the per-frame interrupt tied to end-of-frame.
// - Bit 6 forces a single destination buffer, overriding bit 26.
// - Software flip bit 4 with field bit 5; hardware clears bit 4 when done.
// - Read-only idle bit 3 and current output buffer id in bits 2:1.
// - End-of-frame bit 0 set by hardware, cleared only by writing 1.
// - Source start addresses in bits 28:4 (16-byte units), location in 1:0.
// - Bits 31:30 choose linear or one of three tiled address modes.
// - Bit 28 colour conversion, bit 27 de-blocking, bit 29 selects 565 or 888.
// - Write request raised when output FIFO fill reaches 32 plus bits 24:20.
// - Bit 15 forces RGB32 alpha to 00 or FF.
// - Bit 14 syncs field flipping to display pipe; bit 13 inverts its field.
// - Bits 10:0 hold image size over 1024 for pull-down detection.
module vps_stream_ctrl
    import vps_pkg::*;
#(
    parameter int FRAME_CYC = `VPS_FRAME_CYC,
    parameter int BLEND_CYC = `VPS_BLEND_CYC
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CAPTURE0_FRAME,
    input wire logic CAPTURE1_FRAME,
    input wire logic FIFO_POP,
    output logic ENGINE_ACTIVE,
    output logic [3:0] IN_FORMAT,
    output logic [1:0] SOURCE_SEL,
    output logic [1:0] DEST_BUF_ID,
    output logic [4:0] PROC_FLAGS,
    output logic FIELD_SEL,
    output logic [31:0] LUMA_START,
    output logic [31:0] CHROMA_START,
    output logic [1:0] TILE_MODE,
    output logic [2:0] CSC_FLAGS,
    output logic [7:0] ALPHA_BYTE,
    output logic [1:0] PIPE_FIELD_CTRL,
    output logic [10:0] IMAGE_SIZE_KB,
    output logic MEM_WR_REQ,
    output logic IRQ
);
    vps_word_t strm_r;
    vps_word_t luma_r;
    vps_word_t chroma_r;
    vps_word_t mode_r;
    vps_state_e state_r;
    vps_state_e state_nxt;
    logic [15:0] frame_cnt_r;
    logic [7:0] blend_cnt_r;
    logic [1:0] buf_id_r;
    logic eof_r;
    logic flipq_pend_r;
    logic [31:0] prdata_r;
    logic wr_acc;
    logic rd_acc;
    logic frame_done;
    logic start_req;
    logic fifo_full;
    logic [6:0] fifo_level;
    logic blend_clr;
    logic flip_clr;
    logic flip_wr;

    // Decode of a register offset against the map
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // Zero-wait slave: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign rd_acc = PSEL && PENABLE && !PWRITE;
    assign PSLVERR = PSEL && PENABLE && !(hit(PADDR, `VPS_OFF_STREAM_CTRL) || hit(PADDR, `VPS_OFF_SRC_LUMA)
        || hit(PADDR, `VPS_OFF_SRC_CHROMA) || hit(PADDR, `VPS_OFF_ADDR_MODE));

    // A frame starts from a software flip or an arriving capture frame on the routed path
    always_comb begin
        case (strm_r[`VPS_F_SRC_HI:`VPS_F_SRC_LO])
            2'b00: start_req = strm_r[`VPS_B_SW_FLIP] || flipq_pend_r;
            2'b10: start_req = CAPTURE0_FRAME;
            2'b11: start_req = CAPTURE1_FRAME;
            default: start_req = 1'b0; // Reserved source code never starts a frame
        endcase
    end

    // Flip control state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            VPS_IDLE: begin
                if (strm_r[`VPS_B_ENABLE] && start_req) begin
                    state_nxt = VPS_LOAD;
                end
            end
            VPS_LOAD: state_nxt = VPS_RUN;
            VPS_RUN: begin
                if (!strm_r[`VPS_B_ENABLE]) begin
                    state_nxt = VPS_IDLE;
                end else if (frame_cnt_r == 16'(FRAME_CYC - 1)) begin
                    state_nxt = VPS_DRAIN;
                end
            end
            VPS_DRAIN: state_nxt = VPS_DONE;
            VPS_DONE: state_nxt = VPS_IDLE;
            default: state_nxt = VPS_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state_r <= VPS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign frame_done = (state_r == VPS_DONE);

    // Hardware clears of the self-clearing request bits, and a software flip write
    assign blend_clr = (blend_cnt_r == 8'(BLEND_CYC));
    assign flip_clr = frame_done && !flipq_pend_r;
    assign flip_wr = wr_acc && hit(PADDR, `VPS_OFF_STREAM_CTRL) && PWDATA[`VPS_B_SW_FLIP];

    // Frame length counter; a long frame stays bounded by FRAME_CYC
    always_ff @(posedge MCLK) begin
        if (SRST || state_r != VPS_RUN) begin
            frame_cnt_r <= 16'h0000;
        end else begin
            frame_cnt_r <= frame_cnt_r + 16'h0001;
        end
    end

    // Destination buffer rotation; single mode overrides the triple choice
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            buf_id_r <= 2'h0;
        end else if (frame_done) begin
            if (strm_r[`VPS_B_SINGLE]) begin
                buf_id_r <= 2'h0;
            end else if (strm_r[`VPS_B_TRIPLE]) begin
                buf_id_r <= (buf_id_r >= 2'h2) ? 2'h0 : buf_id_r + 2'h1;
            end else begin
                buf_id_r <= (buf_id_r == 2'h0) ? 2'h1 : 2'h0;
            end
        end
    end

    // A flip written while busy waits here; its presence shows as queue full
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            flipq_pend_r <= 1'b0;
        end else if (wr_acc && hit(PADDR, `VPS_OFF_STREAM_CTRL) && PWDATA[`VPS_B_SW_FLIP] && state_r != VPS_IDLE) begin
            flipq_pend_r <= 1'b1;
        end else if (state_r == VPS_LOAD) begin
            flipq_pend_r <= 1'b0;
        end
    end

    // Sub-picture blend timer starts when software requests a blend
    always_ff @(posedge MCLK) begin
        if (SRST || !strm_r[`VPS_B_SUBPIC_FLIP]) begin
            blend_cnt_r <= 8'h00;
        end else if (blend_cnt_r != 8'(BLEND_CYC)) begin
            blend_cnt_r <= blend_cnt_r + 8'h01;
        end
    end

    // End-of-frame status: hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            eof_r <= 1'b0;
        end else if (frame_done) begin
            eof_r <= 1'b1;
        end else if (wr_acc && hit(PADDR, `VPS_OFF_STREAM_CTRL) && PWDATA[`VPS_B_EOF]) begin
            eof_r <= 1'b0;
        end
    end

    // Stream control: writable fields; self-clearing flip bits dropped by hardware
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            strm_r <= `VPS_RST_WORD;
        end else begin
            if (wr_acc && hit(PADDR, `VPS_OFF_STREAM_CTRL)) begin
                strm_r <= PWDATA & `VPS_STRM_RW_MASK;
                // A write in the cycle of a hardware clear must not keep a finished request alive
                strm_r[`VPS_B_SUBPIC_FLIP] <= PWDATA[`VPS_B_SUBPIC_FLIP]
                    | (strm_r[`VPS_B_SUBPIC_FLIP] & !blend_clr);
                strm_r[`VPS_B_SW_FLIP] <= PWDATA[`VPS_B_SW_FLIP] | (strm_r[`VPS_B_SW_FLIP] & !flip_clr);
            end
            if (blend_cnt_r == 8'(BLEND_CYC) && !(wr_acc && hit(PADDR, `VPS_OFF_STREAM_CTRL))) begin
                strm_r[`VPS_B_SUBPIC_FLIP] <= 1'b0;
            end
            if (frame_done && !flipq_pend_r && !(wr_acc && hit(PADDR, `VPS_OFF_STREAM_CTRL))) begin
                strm_r[`VPS_B_SW_FLIP] <= 1'b0;
            end
        end
    end

    // Source addresses and address-mode control
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            luma_r <= `VPS_RST_WORD;
            chroma_r <= `VPS_RST_WORD;
            mode_r <= `VPS_RST_WORD;
        end else if (wr_acc) begin
            if (hit(PADDR, `VPS_OFF_SRC_LUMA)) begin
                luma_r <= PWDATA & `VPS_ADDR_RW_MASK;
            end
            if (hit(PADDR, `VPS_OFF_SRC_CHROMA)) begin
                chroma_r <= PWDATA & `VPS_ADDR_RW_MASK;
            end
            if (hit(PADDR, `VPS_OFF_ADDR_MODE)) begin
                mode_r <= PWDATA & `VPS_MODE_RW_MASK;
            end
        end
    end

    // Read mux, registered; unmapped offsets read zero
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            prdata_r <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            prdata_r <= 32'h00000000;
            if (hit(PADDR, `VPS_OFF_STREAM_CTRL)) begin
                prdata_r <= strm_r;
                prdata_r[`VPS_B_FLIPQ_FULL] <= flipq_pend_r;
                prdata_r[`VPS_F_FSM_HI:`VPS_F_FSM_LO] <= state_r;
                prdata_r[`VPS_B_IDLE] <= (state_r == VPS_IDLE);
                prdata_r[`VPS_F_BUFID_HI:`VPS_F_BUFID_LO] <= buf_id_r;
                prdata_r[`VPS_B_EOF] <= eof_r;
            end else if (hit(PADDR, `VPS_OFF_SRC_LUMA)) begin
                prdata_r <= luma_r;
            end else if (hit(PADDR, `VPS_OFF_SRC_CHROMA)) begin
                prdata_r <= chroma_r;
            end else if (hit(PADDR, `VPS_OFF_ADDR_MODE)) begin
                prdata_r <= mode_r;
            end
        end
    end
    assign PRDATA = rd_acc ? prdata_r : 32'h00000000;

    // Output FIFO level tracking; running frames push one level per cycle
    vps_fifo_level #(
        .LEVELS(`VPS_FIFO_LEVELS)
    ) u_fifo (
        .MCLK(MCLK),
        .SRST(SRST),
        .push(state_r == VPS_RUN),
        .pop(FIFO_POP),
        .thr_extra(mode_r[`VPS_F_THR_HI:`VPS_F_THR_LO]),
        .wr_req(MEM_WR_REQ),
        .full(fifo_full),
        .level(fifo_level)
    );

    // Configuration fan-out to the datapath
    assign ENGINE_ACTIVE = (state_r != VPS_IDLE);
    assign IN_FORMAT = strm_r[`VPS_F_FMT_HI:`VPS_F_FMT_LO];
    assign SOURCE_SEL = strm_r[`VPS_F_SRC_HI:`VPS_F_SRC_LO];
    assign DEST_BUF_ID = buf_id_r;
    assign PROC_FLAGS = {strm_r[`VPS_B_ADV_DEINT], strm_r[`VPS_B_VLPF], strm_r[`VPS_B_CHROMA_FIELD],
        strm_r[`VPS_B_FRAME2FIELD], strm_r[`VPS_B_FIELD2FRAME]};
    assign FIELD_SEL = strm_r[`VPS_B_SW_BOTTOM] ^ strm_r[`VPS_B_INV_FIELD];
    assign LUMA_START = luma_r;
    assign CHROMA_START = chroma_r;
    assign TILE_MODE = mode_r[`VPS_F_TILE_HI:`VPS_F_TILE_LO];
    // Packing only matters for YUV sources with conversion on
    assign CSC_FLAGS = {mode_r[`VPS_B_PACK32] & mode_r[`VPS_B_CSC] & IN_FORMAT[2] | mode_r[`VPS_B_PACK32]
        & mode_r[`VPS_B_CSC] & IN_FORMAT[3], mode_r[`VPS_B_CSC], mode_r[`VPS_B_DEBLOCK]};
    assign ALPHA_BYTE = mode_r[`VPS_B_ALPHA_FF] ? 8'hFF : 8'h00;
    assign PIPE_FIELD_CTRL = {mode_r[`VPS_B_PIPE_SYNC], mode_r[`VPS_B_PIPE_INV]};
    assign IMAGE_SIZE_KB = mode_r[`VPS_F_SIZE_HI:`VPS_F_SIZE_LO];
    assign IRQ = eof_r & strm_r[`VPS_B_IRQ_EN];

    // Named steps of a frame and of the software requests that the checks below follow
    sequence s_frame_end;
        state_r == VPS_DONE;
    endsequence
    sequence s_eof_clear;
        wr_acc && hit(PADDR, `VPS_OFF_STREAM_CTRL) && PWDATA[`VPS_B_EOF] && !frame_done;
    endsequence
    sequence s_flip_write;
        flip_wr;
    endsequence
    AST_EOF_SET: assert property (@(posedge MCLK) disable iff (SRST)
        s_frame_end |=> eof_r) else $error("end of frame not flagged");
    AST_EOF_HOLD: assert property (@(posedge MCLK) disable iff (SRST)
        eof_r && !(wr_acc && hit(PADDR, `VPS_OFF_STREAM_CTRL) && PWDATA[0]) |=> eof_r) else $error("eof dropped");
    AST_IRQ_LEVEL: assert property (@(posedge MCLK) disable iff (SRST)
        s_frame_end ##0 (strm_r[7] && !wr_acc) |=> IRQ) else $error("irq not raised after frame");
    AST_DISABLED_IDLE: assert property (@(posedge MCLK) disable iff (SRST)
        !strm_r[`VPS_B_ENABLE] && state_r == VPS_IDLE |=> state_r == VPS_IDLE) else $error("started while off");
    AST_SINGLE_BUF: assert property (@(posedge MCLK) disable iff (SRST)
        s_frame_end ##0 strm_r[6] |=> buf_id_r == 2'h0) else $error("single buffer not kept");
    AST_BUF_RANGE: assert property (@(posedge MCLK) disable iff (SRST)
        buf_id_r != 2'h3) else $error("buffer id out of range");
    AST_BLEND_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
        blend_cnt_r == 8'(BLEND_CYC) && !wr_acc |=> !strm_r[15]) else $error("blend bit not cleared");
    AST_FLIP_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
        s_frame_end ##0 (!flipq_pend_r && !flip_wr) |=> !strm_r[4]) else $error("flip bit not cleared");
    AST_RESERVED_SRC: assert property (@(posedge MCLK) disable iff (SRST)
        strm_r[25:24] == 2'b01 |-> !start_req) else $error("reserved source started");
    AST_IRQ_DROP: assert property (@(posedge MCLK) disable iff (SRST)
        s_eof_clear |=> !IRQ) else $error("irq still high after status clear");
    AST_EOF_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
        s_eof_clear |=> !eof_r) else $error("eof not cleared by write one");
    AST_FLIP_SET: assert property (@(posedge MCLK) disable iff (SRST)
        s_flip_write |=> strm_r[`VPS_B_SW_FLIP]) else $error("flip request lost");
    AST_FLIPQ_PEND: assert property (@(posedge MCLK) disable iff (SRST)
        s_flip_write ##0 state_r != VPS_IDLE |=> flipq_pend_r) else $error("busy flip not queued");
    AST_LOAD_RUN: assert property (@(posedge MCLK) disable iff (SRST)
        state_r == VPS_LOAD |=> state_r == VPS_RUN) else $error("load did not enter run");
    AST_DRAIN_DONE: assert property (@(posedge MCLK) disable iff (SRST)
        state_r == VPS_DRAIN |=> state_r == VPS_DONE) else $error("drain did not finish");
    AST_RUN_LEN: assert property (@(posedge MCLK) disable iff (SRST)
        state_r == VPS_RUN |-> frame_cnt_r < 16'(FRAME_CYC)) else $error("frame ran too long");
    AST_FULL_REQ: assert property (@(posedge MCLK) disable iff (SRST)
        fifo_full |-> MEM_WR_REQ) else $error("full fifo without write request");
    AST_LOW_NO_REQ: assert property (@(posedge MCLK) disable iff (SRST)
        fifo_level < 7'(`VPS_FIFO_BASE_THR) |-> !MEM_WR_REQ) else $error("write request below base threshold");
    AST_RO_ZERO: assert property (@(posedge MCLK) disable iff (SRST)
        (strm_r & ~(`VPS_STRM_RW_MASK | 32'h00008010)) == 32'h00000000) else $error("read-only bit stored");
endmodule : vps_stream_ctrl
`default_nettype wire

//--- verif/vps_far_model.sv
// Far side stand-in: capture engines and the memory drain of the output FIFO
`timescale 1ns/1ps
`default_nettype none
module vps_far_model (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic MEM_WR_REQ,
    input wire logic [1:0] cap_on,
    input wire logic drain_on,
    output logic CAPTURE0_FRAME,
    output logic CAPTURE1_FRAME,
    output logic FIFO_POP
);
    // Capture paths offer a frame only while the bench asks for one
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            CAPTURE0_FRAME <= 1'b0;
            CAPTURE1_FRAME <= 1'b0;
        end else begin
            CAPTURE0_FRAME <= cap_on[0];
            CAPTURE1_FRAME <= cap_on[1];
        end
    end
    // Memory drains one level every other cycle, so it is slower than the engine fills
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            FIFO_POP <= 1'b0;
        end else begin
            FIFO_POP <= drain_on & MEM_WR_REQ & ~FIFO_POP;
        end
    end
endmodule : vps_far_model
`default_nettype wire

//--- verif/tb_video_proc_stream_control.sv
// Self-checking bench for the stream control register bank
`timescale 1ns/1ps
`default_nettype none
`include "vps_map.svh"
module tb_video_proc_stream_control;
    import vps_pkg::*;
    localparam int FCYC = 40;
    localparam logic [11:0] SC = `VPS_OFF_STREAM_CTRL;
    localparam logic [11:0] LU = `VPS_OFF_SRC_LUMA;
    localparam logic [11:0] CH = `VPS_OFF_SRC_CHROMA;
    localparam logic [11:0] AM = `VPS_OFF_ADDR_MODE;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [1:0] cap_on = 2'b00;
    logic drain_on = 1'b0;
    logic [31:0] prdata, luma, chroma, rd, base;
    logic pready, pslverr, cap0, cap1, pop, active, fsel, wreq, irq, serr;
    logic [3:0] fmt;
    logic [1:0] src, bufid, tile, pipe;
    logic [4:0] flags;
    logic [2:0] csc;
    logic [7:0] alpha;
    logic [10:0] isize;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int n, exp_id;

    // Half period of 2.5 ns gives 200 MHz
    always #2.5 mclk = ~mclk;

    vps_stream_ctrl #(.FRAME_CYC(FCYC), .BLEND_CYC(16)) dut (
        .MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CAPTURE0_FRAME(cap0), .CAPTURE1_FRAME(cap1), .FIFO_POP(pop), .ENGINE_ACTIVE(active),
        .IN_FORMAT(fmt), .SOURCE_SEL(src), .DEST_BUF_ID(bufid), .PROC_FLAGS(flags),
        .FIELD_SEL(fsel), .LUMA_START(luma), .CHROMA_START(chroma), .TILE_MODE(tile),
        .CSC_FLAGS(csc), .ALPHA_BYTE(alpha), .PIPE_FIELD_CTRL(pipe), .IMAGE_SIZE_KB(isize),
        .MEM_WR_REQ(wreq), .IRQ(irq));

    vps_far_model far (
        .MCLK(mclk), .SRST(srst), .MEM_WR_REQ(wreq), .cap_on(cap_on), .drain_on(drain_on),
        .CAPTURE0_FRAME(cap0), .CAPTURE1_FRAME(cap1), .FIFO_POP(pop));

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // A hung handshake or poll ends the run as a failure
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            test_done();
        end
    end

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Poll the stream register until masked bits match, bounded
    task wait_sc(input logic [31:0] m, input logic [31:0] v);
        int k;
        k = 0;
        apb(1'b0, SC, 32'h0);
        while ((rd & m) !== v && k < 100) begin
            apb(1'b0, SC, 32'h0);
            k++;
        end
        chk("poll", v, rd & m);
    endtask : wait_sc

    task do_reset;
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
    endtask : do_reset

    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        apb(1'b0, SC, 32'h0); chk("sc_rst", 32'h00000008, rd);
        apb(1'b0, AM, 32'h0); chk("am_rst", 32'h0, rd);
        apb(1'b1, LU, 32'hFFFFFFFF); apb(1'b0, LU, 32'h0); chk("luma", 32'h1FFFFFF3, rd);
        chk("luma_out", 32'h1FFFFFF3, luma);
        apb(1'b1, CH, 32'hFFFFFFFF); apb(1'b0, CH, 32'h0); chk("chroma", 32'h1FFFFFF3, rd);
        chk("chroma_out", 32'h1FFFFFF3, chroma);
        apb(1'b1, AM, 32'hFFFFFFFF); apb(1'b0, AM, 32'h0); chk("am", 32'hF9F0E7FF, rd);
        chk("tile", 32'h3, tile);
        chk("size", 32'h7FF, isize);
        chk("alpha", 32'hFF, alpha);
        chk("pipe", 32'h3, pipe);
        apb(1'b1, AM, 32'h0); apb(1'b0, AM, 32'h0); chk("alpha0", 32'h00, alpha);
        // Unmapped place is refused and reads zero
        apb(1'b1, 12'h3E0, 32'hFFFFFFFF); chk("err_w", 32'h1, serr);
        apb(1'b0, 12'h3E0, 32'h0); chk("err_rd", 32'h0, rd); chk("err_r", 32'h1, serr);
        // Read-only and reserved bits ignore writes
        apb(1'b1, SC, 32'hF7FF00E0); apb(1'b0, SC, 32'h0); chk("sc_rw", 32'hF7DE00E8, rd);
        chk("flags", 32'h1F, flags);
        chk("fsel0", 32'h0, fsel);
        chk("src3", 32'h3, src);
        apb(1'b1, AM, 32'h38000000);
        for (int f = 0; f < 16; f++) begin
            apb(1'b1, SC, {f[3:0], 28'h0080000});
            apb(1'b0, SC, 32'h0);
            chk("fmt", f, fmt);
            chk("csc", {29'h0, f[3] | f[2], 2'b11}, csc);
            chk("fsel1", 32'h1, fsel);
        end
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, SC, {6'h0, s[1:0], 24'h0});
            apb(1'b0, SC, 32'h0);
            chk("src", s, src);
        end
        // Sub-picture blend request self-clears
        apb(1'b1, SC, 32'h00008000); apb(1'b0, SC, 32'h0); chk("blend", 32'h8000, rd & 32'h8000);
        wait_sc(32'h00008000, 32'h0);
        // Flip with the engine off produces no frame
        apb(1'b1, SC, 32'h00000010);
        repeat (4 * FCYC) @(posedge mclk);
        apb(1'b0, SC, 32'h0); chk("off_eof", 32'h0, rd & 32'h1);
        chk("off_act", 32'h0, active);
        // Buffer rotation in double, triple and single modes
        for (int m = 0; m < 3; m++) begin
            do_reset();
            base = 32'h08000080 | (m == 1 ? 32'h04000000 : (m == 2 ? 32'h04000040 : 32'h0));
            for (int k = 1; k < 4; k++) begin
                apb(1'b1, SC, base | 32'h10);
                apb(1'b0, SC, 32'h0); chk("busy", 32'h0, rd & 32'h8);
                chk("fsm_load", 32'h1, rd[10:8]);
                chk("active", 32'h1, active);
                wait_sc(32'h10, 32'h0);
                chk("eof", 32'h1, rd & 32'h1);
                chk("irq", 32'h1, irq);
                exp_id = (m == 0) ? k % 2 : ((m == 1) ? k % 3 : 0);
                chk("bufid", exp_id, bufid);
                chk("bufid_rd", exp_id, rd[2:1]);
                apb(1'b1, SC, base | 32'h1);
                apb(1'b0, SC, 32'h0); chk("eof_clr", 32'h0, rd & 32'h1);
                chk("irq_clr", 32'h0, irq);
            end
        end
        // Write request threshold at its boundary, then drained by memory
        do_reset();
        apb(1'b1, AM, 32'h00900000);
        apb(1'b1, SC, 32'h08000010);
        wait_sc(32'h10, 32'h0);
        chk("irq_off", 32'h0, irq);
        chk("req_hi_thr", 32'h0, wreq);
        apb(1'b1, AM, 32'h00800000); apb(1'b0, AM, 32'h0); chk("req_lo_thr", 32'h1, wreq);
        drain_on <= 1'b1;
        n = 0;
        while (wreq !== 1'b0 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        chk("req_drained", 32'h0, wreq);
        drain_on <= 1'b0;
        // Capture paths start frames on their own
        for (int s = 2; s < 4; s++) begin
            do_reset();
            apb(1'b1, SC, {6'h02, s[1:0], 24'h0});
            cap_on <= (s == 2) ? 2'b01 : 2'b10;
            wait_sc(32'h1, 32'h1);
            cap_on <= 2'b00;
        end
        // A flip written while busy is queued and runs a second frame
        do_reset();
        apb(1'b1, SC, 32'h08000010);
        apb(1'b1, SC, 32'h08000010);
        apb(1'b0, SC, 32'h0); chk("flipq", 32'h1000, rd & 32'h1000);
        wait_sc(32'h10, 32'h0);
        chk("flipq_done", 32'h0, rd & 32'h1000);
        test_done();
    end
endmodule : tb_video_proc_stream_control
`default_nettype wire
